// >>> rtl/i2ct_target.sv
// target end: address decode, ack, abort, high-speed and general call handling
`timescale 1ns/10ps
`include "i2ct_consts.svh"
module i2ct_target import i2ct_pkg::*; (
   // bus side, clocked by the bus clock and data lines
   i2ct_if.target bus,
   // user clock and reset
   input logic clk,
   input logic rst_n,
   // received stream and events
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic gc_reset,
   output logic gc_wake,
   output logic collision,
   output logic hs_mode
);

   // ----------------------------------------------------------------
   // start and stop detection, clocked by data edges
   // ----------------------------------------------------------------
   logic start_tgl_q, start_tgl_d;
   logic stop_tgl_q, stop_tgl_d;
   logic hs_off_q, hs_off_d;
   logic hs_on_q, hs_on_d;

   always_comb begin
      start_tgl_d = bus.scl ? ~start_tgl_q : start_tgl_q;
   end

   always_ff @(negedge bus.sda or negedge rst_n) begin
      if (!rst_n) begin
         start_tgl_q <= 1'b0;
      end else begin
         start_tgl_q <= start_tgl_d;
      end
   end

   // a stop also drops high-speed mode at once, without waiting for a clock
   always_comb begin
      stop_tgl_d = bus.scl ? ~stop_tgl_q : stop_tgl_q;
      hs_off_d = bus.scl ? hs_on_q : hs_off_q;
   end

   always_ff @(posedge bus.sda or negedge rst_n) begin
      if (!rst_n) begin
         stop_tgl_q <= 1'b0;
         hs_off_q <= 1'b0;
      end else begin
         stop_tgl_q <= stop_tgl_d;
         hs_off_q <= hs_off_d;
      end
   end

   // ----------------------------------------------------------------
   // receive state, clock rising edge
   // ----------------------------------------------------------------
   i2ct_tgt_state_type st_q, st_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] rx_byte_q, rx_byte_d;
   logic ack_q, ack_d;
   logic rx_pend_q, rx_pend_d;
   logic start_seen_q, start_seen_d;
   logic stop_seen_q, stop_seen_d;
   logic rx_tgl_q, rx_tgl_d;
   logic gcr_tgl_q, gcr_tgl_d;
   logic gcw_tgl_q, gcw_tgl_d;
   logic coll1_tgl_q, coll1_tgl_d;
   logic [7:0] byte_now;

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      rx_byte_d = rx_byte_q;
      ack_d = ack_q;
      rx_pend_d = rx_pend_q;
      rx_tgl_d = rx_tgl_q;
      gcr_tgl_d = gcr_tgl_q;
      gcw_tgl_d = gcw_tgl_q;
      coll1_tgl_d = coll1_tgl_q;
      hs_on_d = hs_on_q;
      start_seen_d = start_tgl_q;
      stop_seen_d = stop_tgl_q;
      byte_now = {sh_q[6:0], bus.sda};
      if (start_tgl_q != start_seen_q) begin
         // partial byte and pending delivery are dropped
         st_d = TG_ADDR;
         sh_d = {7'h00, bus.sda};
         bit_d = 4'h1;
         ack_d = 1'b0;
         rx_pend_d = 1'b0;
      end else if (stop_tgl_q != stop_seen_q) begin
         st_d = TG_IDLE;
         bit_d = 4'h0;
         ack_d = 1'b0;
         rx_pend_d = 1'b0;
      end else if (bit_q == `I2CT_ACK_BIT) begin
         bit_d = 4'h0;
         ack_d = 1'b0;
         rx_pend_d = 1'b0;
         if (rx_pend_q) begin
            rx_tgl_d = ~rx_tgl_q;
         end
      end else begin
         case (st_q)
            TG_IDLE: begin
            end
            TG_RS_WAIT: begin
               if (bit_q != 4'h0) begin
                  st_d = TG_IGNORE;
               end else if (!bus.sda) begin
                  coll1_tgl_d = ~coll1_tgl_q;
                  st_d = TG_IGNORE;
               end else begin
                  bit_d = 4'h1;
               end
            end
            default: begin
               sh_d = byte_now;
               bit_d = 4'(bit_q + 4'h1);
               if (bit_q == `I2CT_LAST_DATA_BIT) begin
                  ack_d = 1'b0;
                  st_d = TG_IGNORE;
                  case (st_q)
                     TG_ADDR: begin
                        if (byte_now[7:3] == `I2CT_HS_CODE_HI) begin
                           st_d = TG_RS_WAIT;
                           if (hs_on_q == hs_off_q) begin
                              hs_on_d = ~hs_on_q;
                           end
                        end else if (byte_now[7:1] == {`I2CT_ADDR_FIXED, `I2CT_ADDR_LOW}) begin
                           ack_d = 1'b1;
                           // reads carry no content in this front end
                           st_d = byte_now[0] ? TG_IGNORE : TG_DATA;
                        end else if (byte_now == `I2CT_GC_BYTE) begin
                           ack_d = 1'b1;
                           st_d = TG_GC_CMD;
                        end
                     end
                     TG_DATA: begin
                        ack_d = 1'b1;
                        rx_byte_d = byte_now;
                        rx_pend_d = 1'b1;
                        st_d = TG_DATA;
                     end
                     TG_GC_CMD: begin
                        if (byte_now == `I2CT_GC_RESET) begin
                           ack_d = 1'b1;
                           gcr_tgl_d = ~gcr_tgl_q;
                           st_d = TG_GC_DONE;
                        end else if (byte_now == `I2CT_GC_WAKE) begin
                           ack_d = 1'b1;
                           gcw_tgl_d = ~gcw_tgl_q;
                           st_d = TG_GC_DONE;
                        end
                     end
                     TG_GC_DONE: begin
                        st_d = TG_GC_DONE;
                     end
                     default: begin
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge bus.scl or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= TG_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         rx_byte_q <= 8'h00;
         ack_q <= 1'b0;
         rx_pend_q <= 1'b0;
         start_seen_q <= 1'b0;
         stop_seen_q <= 1'b0;
         rx_tgl_q <= 1'b0;
         gcr_tgl_q <= 1'b0;
         gcw_tgl_q <= 1'b0;
         coll1_tgl_q <= 1'b0;
         hs_on_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         rx_byte_q <= rx_byte_d;
         ack_q <= ack_d;
         rx_pend_q <= rx_pend_d;
         start_seen_q <= start_seen_d;
         stop_seen_q <= stop_seen_d;
         rx_tgl_q <= rx_tgl_d;
         gcr_tgl_q <= gcr_tgl_d;
         gcw_tgl_q <= gcw_tgl_d;
         coll1_tgl_q <= coll1_tgl_d;
         hs_on_q <= hs_on_d;
      end
   end

   // ----------------------------------------------------------------
   // line drive, clock falling edge
   // ----------------------------------------------------------------
   // data changes only while the clock is low, so drive moves on falling edges
   logic sda_oe_q, sda_oe_d;
   logic coll2_tgl_q, coll2_tgl_d;
   logic scl_oe_q;

   always_comb begin
      sda_oe_d = (bit_q == `I2CT_ACK_BIT) & ack_q;
      coll2_tgl_d = coll2_tgl_q;
      if (st_q == TG_RS_WAIT && bit_q == 4'h1 && start_tgl_q == start_seen_q) begin
         coll2_tgl_d = ~coll2_tgl_q;
      end
   end

   always_ff @(negedge bus.scl or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe_q <= 1'b0;
         coll2_tgl_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end else begin
         sda_oe_q <= sda_oe_d;
         coll2_tgl_q <= coll2_tgl_d;
         scl_oe_q <= 1'b0;
      end
   end

   assign bus.sda_dev_oe = sda_oe_q;
   assign bus.sda_dev_o = 1'b0;
   assign bus.scl_dev_oe = scl_oe_q;
   assign bus.scl_dev_o = 1'b0;

   // ----------------------------------------------------------------
   // crossing into the user clock domain
   // ----------------------------------------------------------------
   // toggles only change once per byte, so the byte itself is stable when read
   logic [5:0] sy1_q, sy2_q, sy3_q;
   logic [5:0] tg_now, edge_d;
   logic [7:0] rx_data_q, rx_data_d;
   logic rx_valid_q, gc_reset_q, gc_wake_q, coll_q, hs_q;

   always_comb begin
      tg_now = {hs_on_q ^ hs_off_q, coll2_tgl_q, coll1_tgl_q, gcw_tgl_q, gcr_tgl_q, rx_tgl_q};
      edge_d = sy2_q ^ sy3_q;
      rx_data_d = edge_d[0] ? rx_byte_q : rx_data_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_q <= 6'h00;
         sy2_q <= 6'h00;
         sy3_q <= 6'h00;
         rx_data_q <= 8'h00;
         rx_valid_q <= 1'b0;
         gc_reset_q <= 1'b0;
         gc_wake_q <= 1'b0;
         coll_q <= 1'b0;
         hs_q <= 1'b0;
      end else begin
         sy1_q <= tg_now;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         rx_data_q <= rx_data_d;
         rx_valid_q <= edge_d[0];
         gc_reset_q <= edge_d[1];
         gc_wake_q <= edge_d[2];
         coll_q <= edge_d[3] | edge_d[4];
         // selects the pad spike filter and slope for high-speed operation
         hs_q <= sy2_q[5];
      end
   end

   assign rx_data = rx_data_q;
   assign rx_valid = rx_valid_q;
   assign gc_reset = gc_reset_q;
   assign gc_wake = gc_wake_q;
   assign collision = coll_q;
   assign hs_mode = hs_q;

endmodule : i2ct_target

// >>> rtl/i2ct_consts.svh
// constants shared by both ends of the two-wire target front end
`ifndef I2CT_CONSTS_SVH
`define I2CT_CONSTS_SVH

// ----------------------------------------------------------------
// addressing
// ----------------------------------------------------------------
// fixed upper address code: value is arbitrary
`define I2CT_ADDR_FIXED 4'hA
`define I2CT_ADDR_LOW 3'h0
`define I2CT_GC_BYTE 8'h00
`define I2CT_HS_CODE_HI 5'h01
`define I2CT_GC_RESET 8'h06
`define I2CT_GC_WAKE 8'h09

// ----------------------------------------------------------------
// bit framing and timing
// ----------------------------------------------------------------
`define I2CT_LAST_DATA_BIT 4'h7
`define I2CT_ACK_BIT 4'h8
`define I2CT_CLK_NS 100
`define I2CT_SCL_QUARTER_NS 2500
`define I2CT_SCL_QUARTER_CYC 8'((`I2CT_SCL_QUARTER_NS + `I2CT_CLK_NS - 1) / `I2CT_CLK_NS)
`define I2CT_HS_SPIKE_NS 10

`endif

// >>> rtl/i2ct_pkg.sv
// types shared by both ends of the two-wire target front end
package i2ct_pkg;

   typedef enum logic [2:0] {
      TG_IDLE, TG_ADDR, TG_DATA, TG_GC_CMD, TG_GC_DONE, TG_RS_WAIT, TG_IGNORE
   } i2ct_tgt_state_type;

   typedef enum logic [1:0] {
      CT_IDLE, CT_START, CT_BIT, CT_STOP
   } i2ct_ctl_state_type;

   typedef enum logic [1:0] {
      OP_START, OP_WRITE, OP_STOP
   } i2ct_op_type;

endpackage : i2ct_pkg

// >>> rtl/i2ct_if.sv
// two-wire bus between controller end and target end, open drain
`timescale 1ns/10ps
interface i2ct_if;
   logic scl_ctl_o;
   logic scl_ctl_oe;
   logic sda_ctl_o;
   logic sda_ctl_oe;
   logic scl_dev_o;
   logic scl_dev_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic scl;
   logic sda;

   // wired-and with pull-up: any enabled driver of zero pulls the line low
   assign scl = ~((scl_ctl_oe & ~scl_ctl_o) | (scl_dev_oe & ~scl_dev_o));
   assign sda = ~((sda_ctl_oe & ~sda_ctl_o) | (sda_dev_oe & ~sda_dev_o));

   modport target (input scl, input sda, output scl_dev_o, output scl_dev_oe,
                   output sda_dev_o, output sda_dev_oe);
   modport controller (input scl, input sda, output scl_ctl_o, output scl_ctl_oe,
                       output sda_ctl_o, output sda_ctl_oe);
endinterface : i2ct_if

// >>> rtl/i2ct_controller.sv
// controller end: makes the bus clock by division, issues start, byte and stop
`timescale 1ns/10ps
`include "i2ct_consts.svh"
module i2ct_controller import i2ct_pkg::*; (
   // bus side
   i2ct_if.controller bus,
   // clock and reset
   input logic clk,
   input logic rst_n,
   // command
   input logic cmd_valid,
   input i2ct_op_type cmd_op,
   input logic [7:0] cmd_data,
   output logic cmd_ready,
   // response
   output logic rsp_valid,
   output logic rsp_nack
);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   i2ct_ctl_state_type st_q, st_d;
   logic [1:0] ph_q, ph_d;
   logic [7:0] div_q, div_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic scl_oe_q, scl_oe_d;
   logic sda_oe_q, sda_oe_d;
   logic ready_q, ready_d;
   logic rsp_valid_q, rsp_valid_d;
   logic rsp_nack_q, rsp_nack_d;
   logic sda_s1_q, sda_s2_q;
   logic tick;

   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      bit_d = bit_q;
      sh_d = sh_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      ready_d = ready_q;
      rsp_valid_d = 1'b0;
      rsp_nack_d = rsp_nack_q;
      tick = (div_q == 8'(`I2CT_SCL_QUARTER_CYC - 1));
      div_d = tick ? 8'h00 : 8'(div_q + 8'h01);
      if (tick && st_q != CT_IDLE) begin
         ph_d = 2'(ph_q + 2'h1);
      end
      case (st_q)
         CT_IDLE: begin
            div_d = 8'h00;
            ph_d = 2'h0;
            if (cmd_valid && ready_q) begin
               ready_d = 1'b0;
               bit_d = 4'h0;
               sh_d = cmd_data;
               case (cmd_op)
                  OP_START: st_d = CT_START;
                  OP_WRITE: st_d = CT_BIT;
                  default: st_d = CT_STOP;
               endcase
            end
         end
         CT_START: begin
            if (tick) begin
               case (ph_q)
                  2'h0: begin
                     sda_oe_d = 1'b0;
                     scl_oe_d = 1'b1;
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b1;
                  default: begin
                     scl_oe_d = 1'b1;
                     st_d = CT_BIT;
                  end
               endcase
            end
         end
         CT_BIT: begin
            if (tick) begin
               case (ph_q)
                  2'h0: sda_oe_d = (bit_q == `I2CT_ACK_BIT) ? 1'b0 : ~sh_q[7];
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: begin
                  end
                  default: begin
                     scl_oe_d = 1'b1;
                     sh_d = {sh_q[6:0], 1'b0};
                     bit_d = 4'(bit_q + 4'h1);
                     if (bit_q == `I2CT_ACK_BIT) begin
                        rsp_valid_d = 1'b1;
                        rsp_nack_d = sda_s2_q;
                        ready_d = 1'b1;
                        st_d = CT_IDLE;
                     end
                  end
               endcase
            end
         end
         CT_STOP: begin
            if (tick) begin
               case (ph_q)
                  2'h0: begin
                     sda_oe_d = 1'b1;
                     scl_oe_d = 1'b1;
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b0;
                  default: begin
                     rsp_valid_d = 1'b1;
                     rsp_nack_d = 1'b0;
                     ready_d = 1'b1;
                     st_d = CT_IDLE;
                  end
               endcase
            end
         end
         default: st_d = CT_IDLE;
      endcase
   end

   // data returned by the target comes from another clock, so it is synchronised
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= CT_IDLE;
         ph_q <= 2'h0;
         div_q <= 8'h00;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         ready_q <= 1'b1;
         rsp_valid_q <= 1'b0;
         rsp_nack_q <= 1'b0;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         div_q <= div_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         ready_q <= ready_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_nack_q <= rsp_nack_d;
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
      end
   end

   assign bus.scl_ctl_oe = scl_oe_q;
   assign bus.scl_ctl_o = 1'b0;
   assign bus.sda_ctl_oe = sda_oe_q;
   assign bus.sda_ctl_o = 1'b0;
   assign cmd_ready = ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_nack = rsp_nack_q;

endmodule : i2ct_controller

// >>> sim/i2ct_props.sv
// concurrent checks on the two-wire link between controller end and target end
`timescale 1ns/10ps
`include "i2ct_consts.svh"
module i2ct_props (
   // clock and reset
   input logic clk,
   input logic rst_n,
   // resolved wires and target drive
   input logic scl,
   input logic sda,
   input logic scl_dev_o,
   input logic scl_dev_oe,
   input logic sda_dev_o,
   input logic sda_dev_oe,
   // target events
   input logic hs_mode,
   input logic rx_valid
);
   logic scl_q;
   logic sda_q;
   logic start_now;
   logic [3:0] bit_cnt_q;
   logic [3:0] bit_cnt_d;
   logic [7:0] ack_cnt_q;
   logic [7:0] ack_cnt_d;

   // ----------------------------------------------------------------
   // bit position since start, wraps after the ack slot
   // ----------------------------------------------------------------
   assign start_now = scl & scl_q & sda_q & ~sda;
   always_comb begin
      bit_cnt_d = bit_cnt_q;
      if (start_now) begin
         bit_cnt_d = 4'h0;
      end else if (scl & ~scl_q) begin
         bit_cnt_d = (bit_cnt_q == `I2CT_ACK_BIT) ? 4'h0 : bit_cnt_q + 4'h1;
      end
      // wraps only past 255, far beyond the bound checked below
      ack_cnt_d = sda_dev_oe ? ack_cnt_q + 8'h01 : 8'h00;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bit_cnt_q <= 4'h0;
         ack_cnt_q <= 8'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         bit_cnt_q <= bit_cnt_d;
         ack_cnt_q <= ack_cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_start; scl && $fell(sda); endsequence
   sequence s_stop; scl && $rose(sda); endsequence
   sequence s_sr_hs; hs_mode && scl && $fell(sda); endsequence
   sequence s_stop_hs; hs_mode && scl && $rose(sda); endsequence

   a_no_clk_stretch: assert property (!scl_dev_oe)
      else $error("target drives the clock line");
   a_ack_pulls_low: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("target drives data high");
   a_ack_after_byte: assert property ($rose(sda_dev_oe) |-> !scl && bit_cnt_q == 4'h8)
      else $error("ack not after eighth bit");
   a_ack_release: assert property ($fell(sda_dev_oe) |-> !scl && bit_cnt_q == 4'h0)
      else $error("ack not released after ninth clock");
   a_ack_bounded: assert property (ack_cnt_q <= 8'h78)
      else $error("ack held too long");
   a_start_no_ack: assert property (s_start |-> !sda_dev_oe)
      else $error("ack during start");
   a_stop_idle: assert property (s_stop |-> ##1 (!sda_dev_oe) [*8])
      else $error("data driven after stop");
   a_stop_ends_hs: assert property (s_stop_hs |-> ##[1:6] !hs_mode)
      else $error("fast mode kept after stop");
   a_sr_keeps_hs: assert property (s_sr_hs |=> hs_mode [*8])
      else $error("fast mode lost at repeated start");
   a_hs_entry: assert property ($rose(hs_mode) |-> bit_cnt_q == 4'h8 && !sda_dev_oe)
      else $error("fast mode entered off the code byte");
   a_rx_in_ack: assert property (rx_valid |-> sda_dev_oe && scl)
      else $error("byte delivered outside ack slot");
endmodule : i2ct_props

// >>> sim/i2c_target_bus_front_end_tb.sv
// bench: controller end against target end, plus a hand-driven second link
`timescale 1ns/10ps
`include "i2ct_consts.svh"
module i2c_target_bus_front_end_tb import i2ct_pkg::*;;
   localparam logic [7:0] OWN_WR = {`I2CT_ADDR_FIXED, `I2CT_ADDR_LOW, 1'b0};
   localparam logic [7:0] HS_CODE = {`I2CT_HS_CODE_HI, 3'h5};
   logic clk;
   logic rst_n;
   logic cmd_valid;
   i2ct_op_type cmd_op;
   logic [7:0] cmd_data;
   logic cmd_ready, rsp_valid, rsp_nack;
   logic [7:0] rx_data, rx_data2;
   logic rx_valid, rx_valid2, gc_reset, gc_wake, collision, hs_mode;
   logic bb_scl_oe, bb_sda_oe;
   int n_mismatch, samples_checked, cyc, n_rx, n_rx2, n_gcr, n_gcw, n_col, n_rsp;

   i2ct_if bus1();
   i2ct_if bus2();
   // second link: the bench plays controller and may break framing on purpose
   assign bus2.scl_ctl_o = 1'b0;
   assign bus2.sda_ctl_o = 1'b0;
   assign bus2.scl_ctl_oe = bb_scl_oe;
   assign bus2.sda_ctl_oe = bb_sda_oe;

   i2ct_controller i_i2ct_controller (.bus(bus1), .clk(clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_nack(rsp_nack));
   i2ct_target i_i2ct_target (.bus(bus1), .clk(clk), .rst_n(rst_n), .rx_data(rx_data),
      .rx_valid(rx_valid), .gc_reset(gc_reset), .gc_wake(gc_wake), .collision(collision),
      .hs_mode(hs_mode));
   i2ct_target i_i2ct_target_b (.bus(bus2), .clk(clk), .rst_n(rst_n), .rx_data(rx_data2),
      .rx_valid(rx_valid2), .gc_reset(), .gc_wake(), .collision(), .hs_mode());
   i2ct_props i_i2ct_props (.clk(clk), .rst_n(rst_n), .scl(bus1.scl), .sda(bus1.sda),
      .scl_dev_o(bus1.scl_dev_o), .scl_dev_oe(bus1.scl_dev_oe), .sda_dev_o(bus1.sda_dev_o),
      .sda_dev_oe(bus1.sda_dev_oe), .hs_mode(hs_mode), .rx_valid(rx_valid));

   // ----------------------------------------------------------------
   // clock, event counters, hang limit
   // ----------------------------------------------------------------
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1) n_rx++;
      if (rx_valid2 === 1'b1) n_rx2++;
      if (gc_reset === 1'b1) n_gcr++;
      if (gc_wake === 1'b1) n_gcw++;
      if (collision === 1'b1) n_col++;
      if (rsp_valid === 1'b1) n_rsp++;
      if (cyc == 40000) begin
         n_mismatch++;
         close_out();
      end
   end

   task automatic close_out();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s seen %0h want %0h", $time, what, seen, exp);
      end
   endtask : check

   // one controller command; the limit only guards against a dead handshake
   task automatic cmd(input i2ct_op_type op, input logic [7:0] d);
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (2) @(posedge clk);
      k = 0;
      while (cmd_ready !== 1'b1 && k < 3000) begin
         @(posedge clk);
         k++;
      end
   endtask : cmd

   task automatic wr(input logic [7:0] d, input logic nack, input string what);
      cmd(OP_WRITE, d);
      check(rsp_nack, nack, what);
   endtask : wr

   // a start command carries the byte that follows it, answered like a write
   task automatic start_wr(input logic [7:0] d, input logic nack, input string what);
      cmd(OP_START, d);
      check(rsp_nack, nack, what);
   endtask : start_wr

   // ----------------------------------------------------------------
   // hand-driven second link, one quarter bit per call
   // ----------------------------------------------------------------
   task automatic bb(input logic scl_low, input logic sda_low);
      bb_scl_oe <= scl_low;
      bb_sda_oe <= sda_low;
      repeat (25) @(posedge clk);
   endtask : bb

   task automatic bb_send(input logic [7:0] d, input int nb, output logic nack);
      for (int i = 7; i > 7 - nb; i--) begin
         bb(1'b1, ~d[i]);
         bb(1'b0, ~d[i]);
         bb(1'b0, ~d[i]);
         bb(1'b1, ~d[i]);
      end
      nack = 1'b1;
      if (nb == 8) begin
         bb(1'b1, 1'b0);
         bb(1'b0, 1'b0);
         nack = bus2.sda;
         bb(1'b0, 1'b0);
         bb(1'b1, 1'b0);
      end
   endtask : bb_send

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_write();
      int n0, r0;
      n0 = n_rx;
      r0 = n_rsp;
      start_wr(OWN_WR, 1'b0, "own address");
      wr(8'h5A, 1'b0, "data ack");
      check(rx_data, 8'h5A, "first byte");
      wr(8'hC3, 1'b0, "data ack");
      check(rx_data, 8'hC3, "second byte");
      start_wr(OWN_WR, 1'b0, "address after sr");
      check(n_rx - n0, 2, "address not delivered");
      start_wr({OWN_WR[7:1], 1'b1}, 1'b0, "read address");
      wr(8'h11, 1'b1, "read carries no write");
      cmd(OP_STOP, 8'h00);
      repeat (2) @(posedge clk);
      check(n_rx - n0, 2, "read delivered nothing");
      check(n_rsp - r0, 7, "answers per command");
   endtask : t_write

   task automatic t_bad_addr();
      logic [7:0] bad [3];
      int n0;
      bad = '{{`I2CT_ADDR_FIXED, 3'h1, 1'b0}, {4'h6, 3'h0, 1'b0}, {`I2CT_ADDR_FIXED, 3'h7, 1'b0}};
      n0 = n_rx;
      foreach (bad[i]) begin
         start_wr(bad[i], 1'b1, "foreign address");
         wr(OWN_WR, 1'b1, "ignored after nack");
         cmd(OP_STOP, 8'h00);
      end
      check(n_rx - n0, 0, "nothing delivered");
   endtask : t_bad_addr

   task automatic t_gc();
      start_wr(`I2CT_GC_BYTE, 1'b0, "general call");
      wr(`I2CT_GC_RESET, 1'b0, "reset command");
      wr(`I2CT_GC_WAKE, 1'b1, "second command");
      cmd(OP_STOP, 8'h00);
      check(n_gcr, 1, "reset pulses");
      check(n_gcw, 0, "wake suppressed");
      start_wr(`I2CT_GC_BYTE, 1'b0, "general call");
      wr(`I2CT_GC_WAKE, 1'b0, "wake command");
      cmd(OP_STOP, 8'h00);
      check(n_gcw, 1, "wake pulses");
   endtask : t_gc

   task automatic t_hs();
      start_wr(HS_CODE, 1'b1, "fast code nack");
      check(hs_mode, 1'b1, "fast mode on");
      start_wr(OWN_WR, 1'b0, "address in fast mode");
      check(hs_mode, 1'b1, "kept over sr");
      wr(8'h77, 1'b0, "data in fast mode");
      check(rx_data, 8'h77, "fast byte");
      cmd(OP_STOP, 8'h00);
      check(hs_mode, 1'b0, "fast mode off");
   endtask : t_hs

   // after the code a plain byte instead of sr: low first bit, then high first bit
   task automatic t_coll();
      logic [7:0] v [2];
      int n0;
      v = '{8'h00, 8'hFF};
      foreach (v[i]) begin
         n0 = n_col;
         start_wr(HS_CODE, 1'b1, "fast code nack");
         cmd(OP_WRITE, v[i]);
         check(n_col - n0, 1, "collision flagged");
         cmd(OP_STOP, 8'h00);
      end
   endtask : t_coll

   task automatic t_abort();
      logic nk;
      int n0;
      n0 = n_rx2;
      bb(1'b1, 1'b0);
      bb(1'b0, 1'b0);
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
      bb_send(OWN_WR, 8, nk);
      check(nk, 1'b0, "link two address");
      bb_send(8'h96, 4, nk);
      bb(1'b1, 1'b1);
      bb(1'b0, 1'b1);
      bb(1'b0, 1'b0);
      check(n_rx2 - n0, 0, "stop mid byte");
      for (int j = 0; j < 2; j++) begin
         bb(1'b1, 1'b0);
         bb(1'b0, 1'b0);
         bb(1'b0, 1'b1);
         bb(1'b1, 1'b1);
         bb_send(OWN_WR, 8, nk);
         check(nk, 1'b0, "address after abort");
         bb_send(8'h3C, 8 - 4 * (1 - j), nk);
      end
      check(n_rx2 - n0, 1, "only whole byte kept");
      check(rx_data2, 8'h3C, "link two byte");
      bb(1'b1, 1'b1);
      bb(1'b0, 1'b1);
      bb(1'b0, 1'b0);
   endtask : t_abort

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_START;
      cmd_data = 8'h00;
      bb_scl_oe = 1'b0;
      bb_sda_oe = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check(hs_mode, 1'b0, "idle after reset");
      t_write();
      t_bad_addr();
      t_gc();
      t_hs();
      t_coll();
      t_abort();
      close_out();
   end
endmodule : i2c_target_bus_front_end_tb
